// file: design/isr_defs.svh
// Overview of operation
// - Event summary is EVENT_STATUS AND enable mask
// - Enable mask bits 1, 6 always zero
// - Enable mask clears at reset or zero write
// - EVENT_STATUS read returns value, then clears it
// - EVENT_STATUS powers up 0x80, clears by read/CLS
// - EVENT_STATUS bit assignment fixed as listed
// - Error code range selects EVENT_STATUS error bit
// - Request control, user request read zero
// - OPC sets complete bit after pending work
// - OPC query suspends, replies one, bit untouched
// - Clear status clears EVENT_STATUS, requests, errors
// - Service mask gates Request True sources
// - Service mask bits 4, 6, 7 ignored
// - Status bits 0-3 show group done/request
// - Status byte bit 4 reads zero
// - Status bit 5 is event summary
// - Bit 6 request summary, cleared by query
// - READ STB forces bit 6 to zero
// - Self test gates commands, then resets
// - Self test query gives -1, 0, 1
// - Wait command suspends until work done
// - Identification returns four fields
// - Transfer channels 0-3 map to groups 1-4
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH

`define ISR_ESR_RESET    8'h80
`define ISR_ESR_IMPL     8'hbd
`define ISR_ESE_IMPL     8'hbd
`define ISR_SRE_IMPL     8'h2f
`define ISR_ESR_OPC      0
`define ISR_ESR_QYE      2
`define ISR_ESR_DDE      3
`define ISR_ESR_EXE      4
`define ISR_ESR_CME      5
`define ISR_ESR_PON      7
`define ISR_STB_ESB      5
`define ISR_STB_RQS      6

`define ISR_ERR_CMD_HI   16'shff9c
`define ISR_ERR_CMD_LO   16'shff39
`define ISR_ERR_EXE_HI   16'shff38
`define ISR_ERR_EXE_LO   16'shfed5
`define ISR_ERR_DDE_HI   16'shfed4
`define ISR_ERR_DDE_LO   16'shfe71
`define ISR_ERR_QYE_HI   16'shfe70
`define ISR_ERR_QYE_LO   16'shfe0d

`define ISR_TST_FAIL     32'hffffffff
`define ISR_TST_PASS     32'h00000000
`define ISR_TST_BUSY     32'h00000001
`define ISR_OPC_REPLY    32'h00000001
`define ISR_IDN_LAST     2'h3

`endif

// file: design/isr_pkg.sv
`default_nettype none
package isr_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_CLS, OP_ESE_SET, OP_ESE_Q, OP_ESR_Q, OP_IDN_Q, OP_OPC, OP_OPC_Q,
        OP_RST, OP_SRE_SET, OP_SRE_Q, OP_STB_Q, OP_TST, OP_TST_Q, OP_WAI
    } isr_op_t;

    typedef struct packed {
        isr_op_t     op;
        logic        has_arg;
        logic [7:0]  arg;
    } isr_cmd_t;

    typedef struct packed {
        logic [1:0]  field;
        logic [31:0] data;
    } isr_resp_t;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] code;
    } isr_err_t;

    typedef enum {ST_IDLE, ST_WAIT, ST_IDN} isr_state_t;
endpackage : isr_pkg
`default_nettype wire

// file: design/isr_status.sv
`include "isr_defs.svh"
`default_nettype none
module isr_status #(
    parameter logic [31:0] MANUFACTURER_CODE = 32'h00000a01, // Arbitrary value
    parameter logic [31:0] MODEL_CODE        = 32'h00000b02, // Arbitrary value
    parameter logic [31:0] SERIAL_CODE       = 32'h00000001,
    parameter logic [31:0] VERSION_CODE      = 32'h00000100
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire isr_pkg::isr_cmd_t cmd_i,
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    output isr_pkg::isr_resp_t     resp_o,
    output logic                   resp_valid_o,
    input  wire logic              busy_i,
    input  wire isr_pkg::isr_err_t err_i,
    input  wire logic [3:0]        group_done_i,
    input  wire logic              group1_transfer_request_i,
    input  wire logic              group2_transfer_request_i,
    input  wire logic              group3_transfer_request_i,
    input  wire logic              group4_transfer_request_i,
    input  wire logic              read_stb_i,
    output logic [7:0]             read_stb_data_o,
    output logic                   read_stb_valid_o,
    input  wire logic              selftest_done_i,
    input  wire logic              selftest_fail_i,
    output logic                   selftest_start_o,
    output logic                   selftest_running_o,
    output logic                   device_reset_o,
    output logic                   error_queue_clear_o,
    output logic                   request_true_o,
    output logic [7:0]             status_byte_o
);
    import isr_pkg::*;

    logic [7:0]  event_status;
    logic [7:0]  event_status_enable;
    logic [7:0]  service_request_enable;
    logic [3:0]  grp;
    logic        esb;
    logic        srq_q;
    logic        rqs;
    logic        opc_pending;
    logic        wait_opcq;
    logic        st_fail;
    logic [1:0]  idn_idx;
    isr_state_t  state;

    isr_state_t  next_state;
    logic [1:0]  next_idn_idx;
    logic        next_resp_valid;
    isr_resp_t   next_resp;
    logic [7:0]  next_esr;
    logic [7:0]  esr_set;
    logic [7:0]  svc;
    logic [7:0]  stb_now;

    isr_op_t     cmd_op;
    logic [7:0]  cmd_arg;
    logic        take;
    logic        exec;
    logic        pending;
    logic        opc_fire;
    logic        srq_sum;
    logic        srq_rise;
    logic        esr_clear;

    function automatic logic isr_test_allowed(input isr_op_t op);
        logic ok;
        ok = 1'b0;
        case (op)
            OP_ESE_Q, OP_ESR_Q, OP_IDN_Q, OP_STB_Q, OP_SRE_Q,
            OP_TST, OP_TST_Q, OP_WAI, OP_OPC, OP_OPC_Q: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : isr_test_allowed

    function automatic logic [7:0] isr_err_bits(input logic signed [15:0] code);
        logic [7:0] bits;
        bits = 8'h00;
        if (code <= `ISR_ERR_CMD_HI && code >= `ISR_ERR_CMD_LO) begin
            bits[`ISR_ESR_CME] = 1'b1;
        end
        if (code <= `ISR_ERR_EXE_HI && code >= `ISR_ERR_EXE_LO) begin
            bits[`ISR_ESR_EXE] = 1'b1;
        end
        if (code <= `ISR_ERR_DDE_HI && code >= `ISR_ERR_DDE_LO) begin
            bits[`ISR_ESR_DDE] = 1'b1;
        end
        if (code <= `ISR_ERR_QYE_HI && code >= `ISR_ERR_QYE_LO) begin
            bits[`ISR_ESR_QYE] = 1'b1;
        end
        return bits;
    endfunction : isr_err_bits

    assign cmd_op   = cmd_i.op;
    assign cmd_arg  = cmd_i.arg;
    assign take     = cmd_valid_i & cmd_ready_o;
    assign exec     = take & (~selftest_running_o | isr_test_allowed(cmd_op));
    assign pending  = busy_i | selftest_running_o;
    assign opc_fire = opc_pending & ~pending;

    // Event status set and clear, set wins
    always_comb begin
        esr_set = 8'h00;
        if (err_i.valid) begin
            esr_set = isr_err_bits(err_i.code);
        end
        esr_set[`ISR_ESR_OPC] = opc_fire;
    end

    assign esr_clear = exec & ((cmd_op == OP_ESR_Q) | (cmd_op == OP_CLS));
    assign next_esr  = ((esr_clear ? 8'h00 : event_status) | esr_set) & `ISR_ESR_IMPL;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_status <= `ISR_ESR_RESET;
        end else begin
            event_status <= next_esr;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opc_pending <= 1'b0;
        end else if (exec && cmd_op == OP_OPC) begin
            opc_pending <= 1'b1;
        end else if (opc_fire) begin
            opc_pending <= 1'b0;
        end
    end

    // Enable masks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_status_enable <= 8'h00;
        end else if (exec && cmd_op == OP_ESE_SET) begin
            event_status_enable <= cmd_i.has_arg ? (cmd_arg & `ISR_ESE_IMPL) : 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            service_request_enable <= 8'h00;
        end else if (exec && cmd_op == OP_SRE_SET) begin
            service_request_enable <= cmd_i.has_arg ? (cmd_arg & `ISR_SRE_IMPL) : 8'h00;
        end
    end

    // Summaries and status byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grp <= 4'h0;
            esb <= 1'b0;
        end else begin
            grp <= group_done_i | {group4_transfer_request_i, group3_transfer_request_i,
                                   group2_transfer_request_i, group1_transfer_request_i};
            esb <= |(event_status & event_status_enable);
        end
    end

    assign svc      = {2'b00, esb, 1'b0, grp};
    assign srq_sum  = |(svc & service_request_enable);
    assign srq_rise = srq_sum & ~srq_q;
    assign stb_now  = {1'b0, rqs, esb, 1'b0, grp};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            srq_q <= 1'b0;
            rqs   <= 1'b0;
        end else begin
            srq_q <= srq_sum;
            if (srq_rise) begin
                rqs <= 1'b1;
            end else if (exec && (cmd_op == OP_STB_Q || cmd_op == OP_CLS)) begin
                rqs <= 1'b0;
            end
        end
    end

    assign request_true_o = rqs;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_byte_o <= 8'h00;
        end else begin
            status_byte_o <= stb_now;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_stb_valid_o <= 1'b0;
            read_stb_data_o  <= 8'h00;
        end else begin
            read_stb_valid_o <= read_stb_i;
            if (read_stb_i) begin
                read_stb_data_o <= stb_now & ~(8'h01 << `ISR_STB_RQS);
            end
        end
    end

    // Self test and side effects
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            selftest_running_o <= 1'b0;
            selftest_start_o   <= 1'b0;
            st_fail            <= 1'b0;
            device_reset_o     <= 1'b0;
        end else begin
            selftest_start_o <= 1'b0;
            device_reset_o   <= 1'b0;
            if (selftest_running_o && selftest_done_i) begin
                selftest_running_o <= 1'b0;
                st_fail            <= selftest_fail_i;
                device_reset_o     <= 1'b1;
            end else if (exec && cmd_op == OP_TST && !selftest_running_o) begin
                selftest_running_o <= 1'b1;
                selftest_start_o   <= 1'b1;
            end else if (exec && cmd_op == OP_RST) begin
                device_reset_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            error_queue_clear_o <= 1'b0;
        end else begin
            error_queue_clear_o <= exec && cmd_op == OP_CLS;
        end
    end

    // Command sequencing and replies
    always_comb begin
        next_state      = state;
        next_idn_idx    = idn_idx;
        next_resp_valid = 1'b0;
        next_resp       = '0;
        case (state)
            ST_IDLE: begin
                if (exec) begin
                    case (cmd_op)
                        OP_ESE_Q: begin
                            next_resp_valid = 1'b1;
                            next_resp.data  = {24'h000000, event_status_enable};
                        end
                        OP_ESR_Q: begin
                            next_resp_valid = 1'b1;
                            next_resp.data  = {24'h000000, event_status};
                        end
                        OP_SRE_Q: begin
                            next_resp_valid = 1'b1;
                            next_resp.data  = {24'h000000, service_request_enable};
                        end
                        OP_STB_Q: begin
                            next_resp_valid = 1'b1;
                            next_resp.data  = {24'h000000, stb_now};
                        end
                        OP_TST_Q: begin
                            next_resp_valid = 1'b1;
                            next_resp.data  = selftest_running_o ? `ISR_TST_BUSY :
                                              (st_fail ? `ISR_TST_FAIL : `ISR_TST_PASS);
                        end
                        OP_IDN_Q: begin
                            next_state   = ST_IDN;
                            next_idn_idx = 2'h0;
                        end
                        OP_OPC_Q, OP_WAI: begin
                            next_state = ST_WAIT;
                        end
                        default: begin
                            next_state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                if (!pending) begin
                    next_state      = ST_IDLE;
                    next_resp_valid = wait_opcq;
                    next_resp.data  = `ISR_OPC_REPLY;
                end
            end
            ST_IDN: begin
                next_resp_valid = 1'b1;
                next_resp.field = idn_idx;
                case (idn_idx)
                    2'h0:    next_resp.data = MANUFACTURER_CODE;
                    2'h1:    next_resp.data = MODEL_CODE;
                    2'h2:    next_resp.data = SERIAL_CODE;
                    default: next_resp.data = VERSION_CODE;
                endcase
                next_idn_idx = idn_idx + 2'h1;
                if (idn_idx == `ISR_IDN_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state        <= ST_IDLE;
            idn_idx      <= 2'h0;
            wait_opcq    <= 1'b0;
            cmd_ready_o  <= 1'b0;
            resp_valid_o <= 1'b0;
            resp_o       <= '0;
        end else begin
            state        <= next_state;
            idn_idx      <= next_idn_idx;
            cmd_ready_o  <= next_state == ST_IDLE;
            resp_valid_o <= next_resp_valid;
            resp_o       <= next_resp;
            if (exec && state == ST_IDLE) begin
                wait_opcq <= cmd_op == OP_OPC_Q;
            end
        end
    end

    // Checks
    a_esb_summary: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        esb == |($past(event_status) & $past(event_status_enable)))
        else $error("event summary does not match masked status");

    a_ese_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (exec && cmd_op == OP_ESE_SET && cmd_i.has_arg) |=> event_status_enable == ($past(cmd_arg) & 8'hbd))
        else $error("event enable mask load wrong");

    a_ese_noarg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (exec && cmd_op == OP_ESE_SET && !cmd_i.has_arg) |=> event_status_enable == 8'h00)
        else $error("mask command without argument did not load zero");

    a_esr_readclr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (exec && cmd_op == OP_ESR_Q && esr_set == 8'h00) |=> event_status == 8'h00 ##1 !esb)
        else $error("status read did not clear register and summary");

    a_esr_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        event_status[1] == 1'b0 && event_status[6] == 1'b0)
        else $error("unused status bits set");

    a_err_command: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (err_i.valid && err_i.code <= -16'sd100 && err_i.code >= -16'sd199) |=> event_status[5])
        else $error("command error bit not set");

    a_sre_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (exec && cmd_op == OP_SRE_SET && cmd_i.has_arg) |=> service_request_enable == ($past(cmd_arg) & 8'h2f))
        else $error("service enable mask load wrong");

    a_stb_unused: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        status_byte_o[4] == 1'b0 && status_byte_o[7] == 1'b0)
        else $error("unused status byte bits set");

    a_rqs_query: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (exec && cmd_op == OP_STB_Q && !srq_rise) |=> !request_true_o)
        else $error("status query did not clear request bit");

    a_read_stb: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        read_stb_i |=> read_stb_valid_o && !read_stb_data_o[6] && read_stb_data_o[5] == $past(esb))
        else $error("read status byte reply wrong");

    a_test_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (take && selftest_running_o && cmd_op == OP_ESE_SET) |=> $stable(event_status_enable))
        else $error("command acted during self test");

    a_tst_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (exec && cmd_op == OP_TST_Q && selftest_running_o) |=> resp_valid_o && resp_o.data == 32'h1)
        else $error("self test query while running not one");

    a_wait_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (take && cmd_op == OP_WAI && pending) |=> !cmd_ready_o && !resp_valid_o)
        else $error("wait did not suspend commands");

    a_opc_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (opc_pending && !pending) |=> event_status[0])
        else $error("operation complete bit not set");
endmodule : isr_status
`default_nettype wire

// file: verification/isr_commander.sv
`default_nettype none
module isr_commander (
    input  wire logic               clk_i,
    output isr_pkg::isr_cmd_t       cmd_o,
    output logic                    cmd_valid_o,
    input  wire logic               cmd_ready_i,
    input  wire isr_pkg::isr_resp_t resp_i,
    input  wire logic               resp_valid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import isr_pkg::*;

    isr_resp_t got [4];

    initial begin
        cmd_o = '0;
        cmd_valid_o = 1'b0;
    end

    // Command held until the edge that sees ready, then released to junk
    task automatic send(input isr_op_t op, input logic has, input logic [7:0] arg);
        int k;
        @(negedge clk_i);
        cmd_o <= '{op: op, has_arg: has, arg: arg};
        cmd_valid_o <= 1'b1;
        k = 0;
        while (cmd_ready_i !== 1'b1 && k < 500) begin
            @(negedge clk_i);
            k++;
        end
        @(negedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o <= isr_cmd_t'(~cmd_o);
    endtask : send

    // Collects n reply words
    task automatic query(input isr_op_t op, input int n);
        int k;
        int j;
        got = '{default: '1};
        send(op, 1'b0, 8'h00);
        j = 0;
        for (k = 0; k < 500 && j < n; k++) begin
            if (resp_valid_i === 1'b1) begin
                got[j] = resp_i;
                j++;
            end
            if (j < n) @(negedge clk_i);
        end
    endtask : query
endmodule : isr_commander
`default_nettype wire

// file: verification/ieee4882_status_reporting_tb.sv
`default_nettype none
module ieee4882_status_reporting_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import isr_pkg::*;

    // Identity values are arbitrary
    localparam logic [31:0] ID_VAL [4] = '{32'h00001234, 32'h00005678, 32'h00000042, 32'h00000203};

    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    isr_cmd_t    cmd;
    logic        cmd_valid;
    logic        cmd_ready_o;
    isr_resp_t   resp_o;
    logic        resp_valid_o;
    logic        busy_i = 1'b0;
    isr_err_t    err_i = '0;
    logic [3:0]  group_done_i = 4'h0;
    logic [3:0]  xfer_req = 4'h0;
    logic        read_stb_i = 1'b0;
    logic [7:0]  read_stb_data_o;
    logic        read_stb_valid_o;
    logic        selftest_done_i = 1'b0;
    logic        selftest_fail_i = 1'b0;
    logic        selftest_start_o;
    logic        selftest_running_o;
    logic        device_reset_o;
    logic        error_queue_clear_o;
    logic        request_true_o;
    logic [7:0]  status_byte_o;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          n_reset = 0;
    int          n_clear = 0;

    always #5 clk_i = ~clk_i;

    isr_status #(.MANUFACTURER_CODE(ID_VAL[0]), .MODEL_CODE(ID_VAL[1]),
                 .SERIAL_CODE(ID_VAL[2]), .VERSION_CODE(ID_VAL[3])) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready_o),
        .resp_o(resp_o), .resp_valid_o(resp_valid_o), .busy_i(busy_i), .err_i(err_i),
        .group_done_i(group_done_i), .group1_transfer_request_i(xfer_req[0]),
        .group2_transfer_request_i(xfer_req[1]), .group3_transfer_request_i(xfer_req[2]),
        .group4_transfer_request_i(xfer_req[3]), .read_stb_i(read_stb_i), .read_stb_data_o(read_stb_data_o),
        .read_stb_valid_o(read_stb_valid_o), .selftest_done_i(selftest_done_i),
        .selftest_fail_i(selftest_fail_i), .selftest_start_o(selftest_start_o),
        .selftest_running_o(selftest_running_o), .device_reset_o(device_reset_o),
        .error_queue_clear_o(error_queue_clear_o), .request_true_o(request_true_o),
        .status_byte_o(status_byte_o));

    isr_commander cmdr (
        .clk_i(clk_i), .cmd_o(cmd), .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready_o),
        .resp_i(resp_o), .resp_valid_i(resp_valid_o));

    task automatic close_out();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    always @(negedge clk_i) begin
        if (device_reset_o === 1'b1) n_reset++;
        if (error_queue_clear_o === 1'b1) n_clear++;
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    task automatic q(input isr_op_t op, input logic [31:0] exp);
        cmdr.query(op, 1);
        chk(op.name(), cmdr.got[0].data, exp);
    endtask : q

    task automatic raise(input int code);
        @(negedge clk_i);
        err_i <= '{valid: 1'b1, code: 16'(code)};
        @(negedge clk_i);
        err_i <= '{valid: 1'b0, code: ~err_i.code};
    endtask : raise

    task automatic selftest(input logic fail);
        @(negedge clk_i);
        selftest_done_i <= 1'b1;
        selftest_fail_i <= fail;
        @(negedge clk_i);
        selftest_done_i <= 1'b0;
        tick(2);
    endtask : selftest

    initial begin
        int i;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        tick(2);
        q(OP_ESR_Q, 32'h00000080);
        q(OP_ESR_Q, 32'h00000000);
        q(OP_ESE_Q, 32'h00000000);
        q(OP_SRE_Q, 32'h00000000);
        cmdr.send(OP_ESE_SET, 1'b1, 8'hff);
        q(OP_ESE_Q, 32'h000000bd);
        cmdr.send(OP_ESE_SET, 1'b0, 8'hff);
        q(OP_ESE_Q, 32'h00000000);
        cmdr.send(OP_SRE_SET, 1'b1, 8'hff);
        q(OP_SRE_Q, 32'h0000002f);
        for (i = 0; i < 8; i++) begin
            raise(-100 * (i / 2 + 1) - 99 * (i % 2));
            tick(2);
            q(OP_ESR_Q, 32'(8'h20 >> (i / 2)));
        end
        cmdr.send(OP_ESE_SET, 1'b1, 8'h20);
        raise(-150);
        tick(4);
        chk("status_byte", status_byte_o, 8'h60);
        chk("request_true", request_true_o, 1'b1);
        @(negedge clk_i);
        read_stb_i <= 1'b1;
        @(negedge clk_i);
        read_stb_i <= 1'b0;
        chk("read_stb", {read_stb_valid_o, read_stb_data_o}, 9'h120);
        q(OP_STB_Q, 32'h00000060);
        tick(3);
        chk("request_true", request_true_o, 1'b0);
        q(OP_ESR_Q, 32'h00000020);
        tick(4);
        chk("status_byte", status_byte_o, 8'h00);
        cmdr.send(OP_SRE_SET, 1'b1, 8'h01);
        xfer_req <= 4'h4;
        tick(4);
        chk("status_byte", {request_true_o, status_byte_o}, 9'h004);
        xfer_req <= 4'h5;
        group_done_i <= 4'h8;
        tick(4);
        chk("status_byte", {request_true_o, status_byte_o}, 9'h14d);
        raise(-300);
        cmdr.send(OP_CLS, 1'b0, 8'h00);
        tick(4);
        chk("status_byte", {request_true_o, status_byte_o}, 9'h00d);
        chk("queue_clear", n_clear, 1);
        q(OP_ESR_Q, 32'h00000000);
        xfer_req <= 4'h0;
        group_done_i <= 4'h0;
        busy_i <= 1'b1;
        cmdr.send(OP_OPC, 1'b0, 8'h00);
        tick(3);
        q(OP_ESR_Q, 32'h00000000);
        busy_i <= 1'b0;
        tick(3);
        q(OP_ESR_Q, 32'h00000001);
        busy_i <= 1'b1;
        fork
            cmdr.query(OP_OPC_Q, 1);
            begin
                tick(6);
                chk("cmd_ready", cmd_ready_o, 1'b0);
                busy_i <= 1'b0;
            end
        join
        chk("opc_reply", cmdr.got[0].data, 32'h00000001);
        q(OP_ESR_Q, 32'h00000000);
        busy_i <= 1'b1;
        cmdr.send(OP_WAI, 1'b0, 8'h00);
        tick(3);
        chk("cmd_ready", cmd_ready_o, 1'b0);
        busy_i <= 1'b0;
        tick(3);
        chk("cmd_ready", cmd_ready_o, 1'b1);
        q(OP_TST_Q, 32'h00000000);
        cmdr.send(OP_TST, 1'b0, 8'h00);
        tick(2);
        chk("running", selftest_running_o, 1'b1);
        cmdr.send(OP_ESE_SET, 1'b1, 8'h04);
        q(OP_ESE_Q, 32'h00000020);
        q(OP_TST_Q, 32'h00000001);
        selftest(1'b1);
        chk("running", selftest_running_o, 1'b0);
        chk("device_reset", n_reset, 1);
        q(OP_TST_Q, 32'hffffffff);
        cmdr.send(OP_TST, 1'b0, 8'h00);
        tick(2);
        selftest(1'b0);
        q(OP_TST_Q, 32'h00000000);
        cmdr.query(OP_IDN_Q, 4);
        for (i = 0; i < 4; i++) begin
            chk("idn", {cmdr.got[i].field, cmdr.got[i].data}, {2'(i), ID_VAL[i]});
        end
        close_out();
    end
endmodule : ieee4882_status_reporting_tb
`default_nettype wire
